// *** inc/prc_regs.svh ***
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PRC_CLK_KHZ      10000
`define PRC_LOCKOUT_MS   200
`define PRC_HOLD_MS      1000
`define PRC_TICK_MS      100
`define PRC_LOCKOUT_CYC  (`PRC_LOCKOUT_MS * `PRC_CLK_KHZ)
`define PRC_HOLD_CYC     (`PRC_HOLD_MS * `PRC_CLK_KHZ)
`define PRC_TICK_CYC     (`PRC_TICK_MS * `PRC_CLK_KHZ)
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PRC_ADDR_CTRL    4'h0
`define PRC_ADDR_RUNTIME 4'h4
`define PRC_ADDR_STATUS  4'h8
// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define PRC_F_ANA        0
`define PRC_F_RANGE      3
`define PRC_F_DIN1       5
`define PRC_F_DIN2       7
`define PRC_F_DOUT       10
`define PRC_F_TMR        13
`define PRC_CTRL_RST     32'h0000_0000
`define PRC_RUNTIME_RST  16'h0000
`endif

// *** inc/prc_pkg.sv ***
package prc_pkg;
  typedef enum {ST_HALT, ST_PAUSE, ST_RUN, ST_PRIME} prc_state_t;
  typedef enum logic [2:0] {ANA_OFF, ANA_0_5V, ANA_0_10V, ANA_4_20MA,
                            ANA_0_20MA} prc_ana_t;
  typedef enum logic [1:0] {RNG_100, RNG_30, RNG_15} prc_range_t;
  typedef enum logic [1:0] {DIN_OFF, DIN_LEVEL, DIN_PULSE} prc_din_t;
  typedef enum logic [2:0] {D2_OFF, D2_RESET, D2_PRIME, D2_COMB,
                            D2_LEVEL, D2_PULSE} prc_din2_t;
  typedef enum logic [2:0] {DO_ALARM, DO_MOTOR, DO_VOLEND, DO_MOTPUL,
                            DO_VOLPUL} prc_dout_t;
endpackage : prc_pkg

// *** core/prc_core.sv ***
// Summary of operation
// - Analog selection off, 0-5V, 0-10V, 4-20mA, 0-20mA; off disables it.
// - Analog valid above on threshold, invalid only below lower off threshold.
// - In 4-20mA, alarm while below 2mA, cleared automatically above it.
// - Flow range selects 100, 30 or 15 percent full scale.
// - Analog: start gives pause; valid signal runs; below off threshold pauses.
// - After any stop, restart is held off for 0.2 s.
// - Stop press sets hard-stop latch; only start or input 2 clears it.
// - Hard-stop latch is set after power-up.
// - Input 1 enabled makes it sole start source; analog must also be valid.
// - Input 1 off, level or pulse; low means run, high means stop.
// - Pulse mode toggles run and pause on each low-going pulse.
// - Pulse with time counter starts run which ends after set time.
// - Input 2 off, reset, prime, combined, level or pulse.
// - Input 2 reset aborts run, clears errors and latch, leaves paused.
// - Input 2 prime aborts, clears, runs fast prime while held.
// - Combined: falling edge clears; held over 1 s primes until release.
// - Level foot switch runs while held; with timer runs whole cycle.
// - Pulse foot switch toggles run and pause per press.
// - Output shows error, motor running or volume end as level.
// - Output pulses per motor tenth revolution or per 20 microlitres.
// - Analog only in flow mode; disables time counter and volume entry.
// - Autostart at power-up only when enabled, else stays stopped.
`include "prc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module prc_core #(
  parameter int unsigned LOCKOUT_CYC = `PRC_LOCKOUT_CYC,
  parameter int unsigned HOLD_CYC    = `PRC_HOLD_CYC,
  parameter int unsigned TICK_CYC    = `PRC_TICK_CYC,
  parameter int unsigned RT_W        = 16
)(
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic               dig_in1_n,
  input  wire logic               dig_in2_n,
  input  wire logic               ana_above_on,
  input  wire logic               ana_below_off,
  input  wire logic               ana_below_2ma,
  input  wire logic               btn_start,
  input  wire logic               btn_stop,
  input  wire logic               autostart_en,
  input  wire logic               pump_error_in,
  input  wire logic               motor_tick,
  input  wire logic               vol_tick,
  input  wire logic               dout_i,
  output prc_pkg::prc_ana_t       ana_sel,
  output prc_pkg::prc_range_t     flow_range,
  output logic                    motor_run,
  output logic                    prime_fast,
  output logic                    err_clear,
  output logic                    ana_alarm,
  output logic                    dout_o,
  output logic                    dout_oe
);
  import prc_pkg::*;

  localparam int LW = $clog2(LOCKOUT_CYC + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int TW = $clog2(TICK_CYC + 1);

  // Counters below these sizes break the lockout and edge timing
  if (LOCKOUT_CYC < 4 || HOLD_CYC < 2 || TICK_CYC < 1 || RT_W < 1 || RT_W > 16)
  begin : g_bad_param
    $error("prc_core: parameter out of range");
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  prc_ana_t   ana_sel_reg;
  prc_range_t range_reg;
  prc_din_t   din1_reg;
  prc_din2_t  din2_reg;
  prc_dout_t  dout_sel_reg;
  logic       tmr_en_reg;
  logic [RT_W-1:0] runtime_reg;

  // Software writes; factory state has every remote function off
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      {tmr_en_reg, dout_sel_reg, din2_reg, din1_reg, range_reg, ana_sel_reg}
        <= 14'(`PRC_CTRL_RST);
      runtime_reg <= RT_W'(`PRC_RUNTIME_RST);
    end
    else if (reg_wr && reg_addr == `PRC_ADDR_CTRL)
    begin
      ana_sel_reg  <= prc_ana_t'(reg_wdata[`PRC_F_ANA +: 3]);
      range_reg    <= prc_range_t'(reg_wdata[`PRC_F_RANGE +: 2]);
      din1_reg     <= prc_din_t'(reg_wdata[`PRC_F_DIN1 +: 2]);
      din2_reg     <= prc_din2_t'(reg_wdata[`PRC_F_DIN2 +: 3]);
      dout_sel_reg <= prc_dout_t'(reg_wdata[`PRC_F_DOUT +: 3]);
      tmr_en_reg   <= reg_wdata[`PRC_F_TMR];
    end
    else if (reg_wr && reg_addr == `PRC_ADDR_RUNTIME)
      runtime_reg <= reg_wdata[RT_W-1:0];
  end

  assign ana_sel    = ana_sel_reg;
  assign flow_range = range_reg;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Bits: 0 in1 active, 1 in2 active, 2 above on, 3 below off, 4 below 2mA
  logic [4:0] raw, sync1_reg, sync2_reg, prev_reg;
  assign raw = {ana_below_2ma, ana_below_off, ana_above_on, ~dig_in2_n, ~dig_in1_n};

  // Only the second stage feeds logic and edge detection
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      prev_reg  <= 5'h00;
    end
    else
    begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic in1, in2, rise1, rise2;
  assign in1   = sync2_reg[0];
  assign in2   = sync2_reg[1];
  assign rise1 = sync2_reg[0] & ~prev_reg[0];
  assign rise2 = sync2_reg[1] & ~prev_reg[1];

  // ----------------------------------------------------------------
  // Analog validity and alarm
  // ----------------------------------------------------------------
  logic ana_en, ana_valid_reg, ana_alarm_reg;
  assign ana_en = ana_sel_reg inside {ANA_0_5V, ANA_0_10V, ANA_4_20MA, ANA_0_20MA};

  // Hysteresis: a value between thresholds keeps the previous verdict
  always_ff @(posedge clk_sys)
  begin
    if (reset || !ana_en)
      ana_valid_reg <= 1'b0;
    else if (sync2_reg[2])
      ana_valid_reg <= 1'b1;
    else if (sync2_reg[3])
      ana_valid_reg <= 1'b0;
  end

  // Alarm follows the current level, so it clears by itself
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ana_alarm_reg <= 1'b0;
    else
      ana_alarm_reg <= (ana_sel_reg == ANA_4_20MA) && sync2_reg[4];
  end

  assign ana_alarm = ana_alarm_reg;

  // ----------------------------------------------------------------
  // Start source selection
  // ----------------------------------------------------------------
  logic ext1, ext2, dig_en, ext, use_in, use_rise, use_pulse, timed;
  assign ext1     = din1_reg inside {DIN_LEVEL, DIN_PULSE};
  assign ext2     = !ext1 && (din2_reg inside {D2_LEVEL, D2_PULSE});
  assign dig_en   = ext1 || ext2;
  assign ext      = dig_en || ana_en;
  assign use_in   = ext1 ? in1 : in2;
  assign use_rise = ext1 ? rise1 : rise2;
  assign use_pulse = ext1 ? (din1_reg == DIN_PULSE) : (din2_reg == D2_PULSE);
  // Analog control shuts the time counter out
  assign timed    = tmr_en_reg && !ana_en && (runtime_reg != '0);

  // Input 2 service functions; they take priority over everything
  logic clr_hold, hold_done, prime_req;
  logic [HW-1:0] hold_cnt_reg;
  assign clr_hold  = in2 && (din2_reg inside {D2_RESET, D2_PRIME, D2_COMB});
  assign hold_done = (hold_cnt_reg == HW'(HOLD_CYC));
  assign prime_req = in2 && ((din2_reg == D2_PRIME) ||
                             (din2_reg == D2_COMB && hold_done));

  // Combined mode hold time, restarted by every release
  always_ff @(posedge clk_sys)
  begin
    if (reset || !in2 || din2_reg != D2_COMB)
      hold_cnt_reg <= '0;
    else if (!hold_done)
      hold_cnt_reg <= hold_cnt_reg + HW'(1);
  end

  // Error clear pulse on the leading edge of any service function
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      err_clear <= 1'b0;
    else
      err_clear <= rise2 && (din2_reg inside {D2_RESET, D2_PRIME, D2_COMB});
  end

  // ----------------------------------------------------------------
  // Run request
  // ----------------------------------------------------------------
  prc_state_t state_reg, state_next;
  logic tog_reg, busy_reg, manual_reg, boot_reg, vol_end_reg;
  logic tick_en, tmr_expire, dig_want, want;
  logic [LW-1:0] lock_cnt_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic [RT_W-1:0] rt_cnt_reg;

  assign tmr_expire = (state_reg == ST_RUN) && busy_reg && tick_en &&
                      (rt_cnt_reg == RT_W'(1));
  assign dig_want = timed ? (busy_reg && !tmr_expire)
                  : use_pulse ? tog_reg : use_in;
  assign want = ext ? ((dig_en ? dig_want : 1'b1) &&
                       (ana_en ? ana_valid_reg : 1'b1) && !ana_alarm_reg)
                    : manual_reg;

  // Pulse toggle; a stop or abort returns it to the stopped phase
  always_ff @(posedge clk_sys)
  begin
    if (reset || clr_hold || btn_stop || !(state_reg inside {ST_PAUSE, ST_RUN}))
      tog_reg <= 1'b0;
    else if (use_pulse && use_rise)
      tog_reg <= ~tog_reg;
  end

  // Timed run: the start edge launches a whole metering cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset || clr_hold || btn_stop || tmr_expire || !timed)
      busy_reg <= 1'b0;
    else if (!(state_reg inside {ST_PAUSE, ST_RUN}))
      busy_reg <= 1'b0;
    else if (dig_en && use_rise && !busy_reg && state_reg == ST_PAUSE)
      busy_reg <= 1'b1;
  end

  // Tenth-second enable and run time down-counter
  always_ff @(posedge clk_sys)
  begin
    if (reset || state_reg != ST_RUN || tick_en)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
  end
  assign tick_en = (tick_cnt_reg == TW'(TICK_CYC - 1));

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rt_cnt_reg <= '0;
    else if (!busy_reg)
      rt_cnt_reg <= runtime_reg;
    else if (state_reg == ST_RUN && tick_en && rt_cnt_reg != '0)
      rt_cnt_reg <= rt_cnt_reg - RT_W'(1);
  end

  // Manual run request when no remote source is selected
  always_ff @(posedge clk_sys)
  begin
    if (reset || btn_stop || clr_hold)
      manual_reg <= 1'b0;
    else if (btn_start)
      manual_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    if (clr_hold)
      state_next = prime_req ? ST_PRIME : ST_PAUSE;
    else if (btn_stop)
      state_next = ST_HALT;
    else
    begin
      case (state_reg)
        ST_HALT:
          if (btn_start || (boot_reg && autostart_en))
            state_next = ST_PAUSE;
        ST_PAUSE:
          if (want && lock_cnt_reg == '0)
            state_next = ST_RUN;
        ST_RUN:
          if (!want)
            state_next = ST_PAUSE;
        ST_PRIME:
          state_next = ST_PAUSE;
        default:
          state_next = ST_HALT;
      endcase
    end
  end

  // The hard-stop latch is the halted state; power-up lands in it
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      state_reg <= ST_HALT;
    else
      state_reg <= state_next;
  end

  // One-cycle window after reset in which autostart is looked at
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      boot_reg <= 1'b1;
    else
      boot_reg <= 1'b0;
  end

  // Restart lockout, loaded whenever a run ends for any reason
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      lock_cnt_reg <= '0;
    else if (state_reg == ST_RUN && state_next != ST_RUN)
      lock_cnt_reg <= LW'(LOCKOUT_CYC);
    else if (lock_cnt_reg != '0)
      lock_cnt_reg <= lock_cnt_reg - LW'(1);
  end

  // Volume end stays up until the next run starts
  always_ff @(posedge clk_sys)
  begin
    if (reset || (state_reg != ST_RUN && state_next == ST_RUN))
      vol_end_reg <= 1'b0;
    else if (tmr_expire)
      vol_end_reg <= 1'b1;
  end

  assign motor_run  = (state_reg == ST_RUN);
  assign prime_fast = (state_reg == ST_PRIME);

  // ----------------------------------------------------------------
  // Digital output
  // ----------------------------------------------------------------
  logic dout_act, err_any;
  assign err_any = pump_error_in || ana_alarm_reg;

  always_comb
  begin
    case (dout_sel_reg)
      DO_ALARM:  dout_act = err_any;
      DO_MOTOR:  dout_act = (state_reg inside {ST_RUN, ST_PRIME});
      DO_VOLEND: dout_act = vol_end_reg;
      DO_MOTPUL: dout_act = motor_tick;
      DO_VOLPUL: dout_act = vol_tick;
      default:   dout_act = 1'b0;
    endcase
  end

  // Open collector: the transistor pulls low while the output is active
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      dout_oe <= 1'b0;
    else
      dout_oe <= dout_act;
  end
  assign dout_o = 1'b0;

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [31:0] status;
  assign status = {22'h00_0000, pump_error_in, dout_i, (lock_cnt_reg != '0),
                   vol_end_reg, ana_alarm_reg, ana_valid_reg,
                   (state_reg == ST_PRIME), (state_reg == ST_RUN),
                   (state_reg == ST_PAUSE), (state_reg == ST_HALT)};

  // Data stand only in the cycle after the strobe; other cycles read zero
  always_ff @(posedge clk_sys)
  begin
    if (reset || !reg_rd)
      reg_rdata <= 32'h0000_0000;
    else
    begin
      case (reg_addr)
        `PRC_ADDR_CTRL:    reg_rdata <= {18'h0_0000, tmr_en_reg, dout_sel_reg,
                                         din2_reg, din1_reg, range_reg, ana_sel_reg};
        `PRC_ADDR_RUNTIME: reg_rdata <= 32'(runtime_reg);
        `PRC_ADDR_STATUS:  reg_rdata <= status;
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_run_drop;
    state_reg == ST_RUN ##1 state_reg != ST_RUN;
  endsequence

  property p_lockout;
    @(posedge clk_sys) disable iff (reset)
    s_run_drop |-> (state_reg != ST_RUN)[*3];
  endproperty
  a_lockout: assert property (p_lockout) else $error("restart inside lockout");

  property p_halt_hold;
    @(posedge clk_sys) disable iff (reset)
    state_reg == ST_HALT && !btn_start && !clr_hold && !boot_reg |=> state_reg == ST_HALT;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("latch left without clear");

  property p_boot_halt;
    @(posedge clk_sys) disable iff (reset)
    boot_reg && !autostart_en && !btn_start && !clr_hold |=> state_reg == ST_HALT;
  endproperty
  a_boot_halt: assert property (p_boot_halt) else $error("left latch at power-up");

  property p_ana_hyst;
    @(posedge clk_sys) disable iff (reset)
    ana_en && ana_valid_reg && !sync2_reg[3] && $stable(ana_sel_reg) |=> ana_valid_reg;
  endproperty
  a_ana_hyst: assert property (p_ana_hyst) else $error("analog valid lost early");

  property p_alarm;
    @(posedge clk_sys) disable iff (reset)
    ana_sel_reg == ANA_4_20MA && sync2_reg[4] |=> ana_alarm_reg;
  endproperty
  a_alarm: assert property (p_alarm) else $error("under-current alarm missing");

  property p_ana_stop;
    @(posedge clk_sys) disable iff (reset)
    state_reg == ST_RUN && ana_en && !ana_valid_reg && !clr_hold |=> state_reg != ST_RUN;
  endproperty
  a_ana_stop: assert property (p_ana_stop) else $error("ran without valid analog");

  property p_prime;
    @(posedge clk_sys) disable iff (reset)
    din2_reg == D2_PRIME && in2 |=> state_reg == ST_PRIME && prime_fast;
  endproperty
  a_prime: assert property (p_prime) else $error("prime not running");

  property p_comb_early;
    @(posedge clk_sys) disable iff (reset)
    din2_reg == D2_COMB && rise2 |=> (state_reg != ST_PRIME)[*2];
  endproperty
  a_comb_early: assert property (p_comb_early) else $error("combined primed early");

  property p_dout_motor;
    @(posedge clk_sys) disable iff (reset)
    dout_sel_reg == DO_MOTOR && state_reg == ST_RUN |=> dout_oe;
  endproperty
  a_dout_motor: assert property (p_dout_motor) else $error("motor output missing");

  property p_timed_end;
    @(posedge clk_sys) disable iff (reset)
    tmr_expire |=> state_reg != ST_RUN && vol_end_reg;
  endproperty
  a_timed_end: assert property (p_timed_end) else $error("timed run did not end");

endmodule : prc_core
`default_nettype wire

// *** testbench/prc_ext_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// External controller or foot switch
// ------------------------------------
module prc_ext_ctrl #(
  parameter int MIN_LOW = 4
)(
  input  wire logic clk_sys,
  input  wire logic act1,
  input  wire logic act2,
  output var  logic dig_in1_n,
  output var  logic dig_in2_n
);
  int cnt1 = 0;
  int cnt2 = 0;
  // Pins idle high on their pull-ups
  initial {dig_in1_n, dig_in2_n} = 2'b11;
  // Short requests are stretched and driven from a flop, so no bounce reaches the pins
  always @(posedge clk_sys)
  begin
    cnt1      <= act1 ? MIN_LOW : (cnt1 > 0 ? cnt1 - 1 : 0);
    cnt2      <= act2 ? MIN_LOW : (cnt2 > 0 ? cnt2 - 1 : 0);
    dig_in1_n <= !(act1 || cnt1 > 1);
    dig_in2_n <= !(act2 || cnt2 > 1);
  end
endmodule : prc_ext_ctrl
`default_nettype wire

// *** testbench/tb_pump_remote_input_control.sv ***
`include "prc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_pump_remote_input_control;
  import prc_pkg::*;
  // ------------------------------------
  // Bench plumbing
  // ------------------------------------
  localparam int B_START = 0, IN1 = 1, IN2 = 2, B_STOP = 3, TCK = 4, ERR = 5, VTK = 6;
  localparam int MR = 0, PF = 1, AL = 2, DO = 3;
  logic        clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, d;
  logic [6:0]  ctl = '0;
  logic        ana_above_on = 0, ana_below_off = 1, ana_below_2ma = 0, autostart = 0;
  logic        dig_in1_n, dig_in2_n, motor_run, prime_fast, err_clear;
  logic        ana_alarm, dout_o, dout_oe;
  prc_ana_t    ana_sel;
  prc_range_t  flow_range;
  int          err_total = 0, samples_checked = 0, cycles = 0, clears = 0, n;

  prc_core #(.LOCKOUT_CYC(16), .HOLD_CYC(16), .TICK_CYC(4)) prc_core_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dig_in1_n(dig_in1_n),
    .dig_in2_n(dig_in2_n), .ana_above_on(ana_above_on), .ana_below_off(ana_below_off),
    .ana_below_2ma(ana_below_2ma), .btn_start(ctl[B_START]), .btn_stop(ctl[B_STOP]),
    .autostart_en(autostart), .pump_error_in(ctl[ERR]), .motor_tick(ctl[TCK]),
    .vol_tick(ctl[VTK]), .dout_i(~dout_oe), .ana_sel(ana_sel), .flow_range(flow_range),
    .motor_run(motor_run), .prime_fast(prime_fast), .err_clear(err_clear),
    .ana_alarm(ana_alarm), .dout_o(dout_o), .dout_oe(dout_oe));

  prc_ext_ctrl prc_ext_ctrl_inst (.clk_sys(clk_sys), .act1(ctl[IN1]), .act2(ctl[IN2]),
    .dig_in1_n(dig_in1_n), .dig_in2_n(dig_in2_n));

  always #50 clk_sys = ~clk_sys;
  // Counts error-clear pulses and cuts a hang short
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (err_clear === 1'b1) clears <= clears + 1;
    if (cycles == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc

  task automatic wr(logic [3:0] a, logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    cyc(1);
    reg_wr    <= 1'b0;
    cyc(1);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [3:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    cyc(1);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    cyc(1);
  endtask : rd

  // One-cycle press of a button, pin request or tick
  task automatic tap(int b);
    ctl[b] <= 1'b1;
    cyc(1);
    ctl[b] <= 1'b0;
  endtask : tap

  function automatic logic [31:0] cfg(int ana, int rng, int d1, int d2, int dout, int tmr);
    return 32'(ana) | 32'(rng) << 3 | 32'(d1) << 5 | 32'(d2) << 7 | 32'(dout) << 10
           | 32'(tmr) << 13;
  endfunction : cfg

  function automatic logic obs(int p);
    case (p)
      MR: return motor_run;
      PF: return prime_fast;
      AL: return ana_alarm;
      default: return dout_oe;
    endcase
  endfunction : obs

  // Bounded wait; the pins pass synchronisers, so exact cycles are not fixed
  task automatic wait_sig(int p, logic v, int k, string what);
    for (int i = 0; i < k; i++)
    begin
      cyc(1);
      #1;
      if (obs(p) === v) break;
    end
    check(what, obs(p), v);
  endtask : wait_sig

  task automatic hold_sig(int p, logic v, int k, string what);
    logic bad = 1'b0;
    repeat (k)
    begin
      cyc(1);
      #1;
      if (obs(p) !== v) bad = 1'b1;
    end
    check(what, bad, 1'b0);
  endtask : hold_sig

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------
  // Scenarios
  // ------------------------------------
  task automatic t_boot;
    rd(`PRC_ADDR_CTRL);
    check("ctrl reset", d, 32'h0000_0000);
    rd(`PRC_ADDR_STATUS);
    check("status halt", d[3:0], 4'h1);
    rd(4'hC);
    check("unmapped", d, 32'h0000_0000);
    for (int a = 0; a < 5; a++)
    begin
      wr(`PRC_ADDR_CTRL, cfg(a, a % 3, 0, 0, 0, 0));
      check("ana_sel", ana_sel, a);
      check("flow_range", flow_range, a % 3);
    end
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_LEVEL, 0, 0, 0));
    ctl[IN1] <= 1'b1;
    hold_sig(MR, 1'b0, 20, "halt at power-up");
  endtask : t_boot

  task automatic t_level;
    ctl[IN1] <= 1'b0;
    // The stretched pin must be released before the start press
    cyc(8);
    tap(B_START);
    hold_sig(MR, 1'b0, 8, "start needs input 1");
    ctl[IN1] <= 1'b1;
    wait_sig(MR, 1'b1, 10, "level run");
    ctl[IN1] <= 1'b0;
    wait_sig(MR, 1'b0, 10, "level stop");
    ctl[IN1] <= 1'b1;
    hold_sig(MR, 1'b0, 12, "restart lockout");
    wait_sig(MR, 1'b1, 12, "run after lockout");
  endtask : t_level

  task automatic t_stop_reset;
    tap(B_STOP);
    wait_sig(MR, 1'b0, 4, "stop press");
    hold_sig(MR, 1'b0, 30, "latch holds");
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_LEVEL, D2_RESET, 0, 0));
    n = clears;
    tap(IN2);
    wait_sig(MR, 1'b1, 40, "reset frees latch");
    check("reset clears", clears != n, 1'b1);
    ctl[IN1] <= 1'b0;
    wait_sig(MR, 1'b0, 10, "level stop");
  endtask : t_stop_reset

  task automatic t_pulse;
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_PULSE, 0, 0, 0));
    cyc(20);
    tap(IN1);
    wait_sig(MR, 1'b1, 10, "pulse start");
    hold_sig(MR, 1'b1, 20, "pulse holds");
    tap(IN1);
    wait_sig(MR, 1'b0, 10, "pulse stop");
    cyc(20);
    wr(`PRC_ADDR_RUNTIME, 32'h0000_0003);
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_PULSE, 0, 0, 1));
    tap(IN1);
    wait_sig(MR, 1'b1, 10, "timed start");
    hold_sig(MR, 1'b1, 8, "timed run");
    wait_sig(MR, 1'b0, 8, "timed end");
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_PULSE, 0, DO_VOLEND, 1));
    wait_sig(DO, 1'b1, 3, "volume end");
  endtask : t_pulse

  task automatic t_input2;
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_OFF, D2_PRIME, 0, 0));
    ctl[IN2] <= 1'b1;
    wait_sig(PF, 1'b1, 10, "prime on");
    hold_sig(PF, 1'b1, 10, "prime held");
    ctl[IN2] <= 1'b0;
    wait_sig(PF, 1'b0, 10, "prime off");
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_OFF, D2_COMB, 0, 0));
    n = clears;
    tap(IN2);
    hold_sig(PF, 1'b0, 30, "short no prime");
    check("edge clears", clears != n, 1'b1);
    ctl[IN2] <= 1'b1;
    hold_sig(PF, 1'b0, 10, "prime waits");
    wait_sig(PF, 1'b1, 20, "long prime");
    ctl[IN2] <= 1'b0;
    wait_sig(PF, 1'b0, 10, "prime release");
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_OFF, D2_LEVEL, 0, 0));
    ctl[IN2] <= 1'b1;
    wait_sig(MR, 1'b1, 30, "foot held");
    ctl[IN2] <= 1'b0;
    wait_sig(MR, 1'b0, 10, "foot release");
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, DIN_OFF, D2_PULSE, 0, 0));
    cyc(20);
    tap(IN2);
    wait_sig(MR, 1'b1, 10, "foot toggle on");
    tap(IN2);
    wait_sig(MR, 1'b0, 10, "foot toggle off");
  endtask : t_input2

  task automatic t_analog;
    wr(`PRC_ADDR_CTRL, cfg(ANA_0_5V, RNG_15, 0, 0, 0, 0));
    tap(B_START);
    hold_sig(MR, 1'b0, 8, "no signal paused");
    ana_below_off <= 1'b0;
    ana_above_on  <= 1'b1;
    wait_sig(MR, 1'b1, 20, "signal runs");
    ana_above_on  <= 1'b0;
    hold_sig(MR, 1'b1, 8, "hysteresis");
    ana_below_off <= 1'b1;
    wait_sig(MR, 1'b0, 10, "below off");
    wr(`PRC_ADDR_CTRL, cfg(ANA_4_20MA, 0, 0, 0, 0, 0));
    ana_below_2ma <= 1'b1;
    wait_sig(AL, 1'b1, 6, "alarm set");
    ana_below_2ma <= 1'b0;
    wait_sig(AL, 1'b0, 6, "alarm clear");
  endtask : t_analog

  task automatic t_dout;
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, 0, 0, DO_MOTOR, 0));
    // A start left over from the analog scenario is cancelled first
    tap(B_STOP);
    hold_sig(MR, 1'b0, 20, "manual idle");
    tap(B_START);
    wait_sig(MR, 1'b1, 20, "manual run");
    wait_sig(DO, 1'b1, 3, "motor output");
    check("dout_o", dout_o, 1'b0);
    tap(B_STOP);
    wait_sig(DO, 1'b0, 6, "motor output off");
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, 0, 0, DO_MOTPUL, 0));
    hold_sig(DO, 1'b0, 3, "no tick quiet");
    tap(TCK);
    #1 check("tick pulse", dout_oe, 1'b1);
    wait_sig(DO, 1'b0, 3, "tick pulse ends");
    wr(`PRC_ADDR_CTRL, cfg(ANA_OFF, 0, 0, 0, DO_VOLPUL, 0));
    tap(VTK);
    #1 check("vol pulse", dout_oe, 1'b1);
    wr(`PRC_ADDR_CTRL, 32'h0000_0000);
    ctl[ERR] <= 1'b1;
    wait_sig(DO, 1'b1, 3, "error output");
    rd(`PRC_ADDR_STATUS);
    check("status error pin", d[9:8], 2'b10);
    ctl[ERR] <= 1'b0;
    wait_sig(DO, 1'b0, 3, "error output off");
  endtask : t_dout

  // Second reset with autostart on: the boot cycle leaves the latch
  task automatic t_autostart;
    autostart <= 1'b1;
    reset     <= 1'b1;
    cyc(2);
    reset     <= 1'b0;
    cyc(2);
    rd(`PRC_ADDR_STATUS);
    check("autostart pause", d[3:0], 4'h2);
  endtask : t_autostart

  // Main sequence
  initial
  begin
    cyc(2);
    reset <= 1'b0;
    cyc(1);
    t_boot();
    t_level();
    t_stop_reset();
    t_pulse();
    t_input2();
    t_analog();
    t_dout();
    t_autostart();
    wrap_up();
  end
endmodule : tb_pump_remote_input_control
`default_nettype wire
